//--- rtl/dma_handshake.sv
/*
  DMA request, grant, terminal count and ready handshake of a four-channel engine.
  Assumes the slave drives ready from outside the clock domain, peripherals hold
  requests until granted, and the processor cycle indicator comes from on-chip logic.
*/
// What this block does
// - Ready low stretches; high lets cycle finish
// - Stretch only DMA core cycles
// - Processor accesses are never lengthened
// - Drive active-low grant to requesting channel
// - Pulse terminal count at transfer end
`timescale 1ns/1ps
module dma_handshake (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // Transfer programming from the engine core
  input  wire logic        xfer_start,
  input  wire logic [15:0] xfer_len,
  // Processor bus cycle in progress
  input  wire logic        cpu_cycle,
  // Pins
  input  wire logic [3:0]  dma_request_lines,
  input  wire logic        ready,
  output logic      [3:0]  dma_grant_n_lines,
  output logic             transfer_count_done,
  output logic             dma_cycle_active,
  output logic             cpu_cycle_done
);

  // ---------------------------------------------------------------
  // Reset and input synchronisers
  // ---------------------------------------------------------------
  logic       rst_s1_reg;
  logic       rst_s2_reg;
  logic [3:0] req_s1_reg;
  logic [3:0] req_s2_reg;
  logic       rdy_s1_reg;
  logic       rdy_s2_reg;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      req_s1_reg <= 4'h0;
      req_s2_reg <= 4'h0;
      rdy_s1_reg <= 1'b1;
      rdy_s2_reg <= 1'b1;
    end else begin
      req_s1_reg <= dma_request_lines;
      req_s2_reg <= req_s1_reg;
      rdy_s1_reg <= ready;
      rdy_s2_reg <= rdy_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [1:0] pick_channel(input logic [3:0] req);
    pick_channel = 2'h0;
    for (int i = dma_hs_pkg::CHANNELS - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_channel = 2'(i);
      end
    end
  endfunction

  function automatic logic is_last(input logic [15:0] left);
    is_last = (left <= 16'h0001);
  endfunction

  // ---------------------------------------------------------------
  // Handshake state machine
  // ---------------------------------------------------------------
  dma_hs_pkg::dma_state_t state_reg;
  dma_hs_pkg::dma_state_t state_next;
  logic [1:0]  ch_reg;
  logic [1:0]  ch_next;
  logic [3:0]  cyc_reg;
  logic [3:0]  cyc_next;
  logic [15:0] left_reg;
  logic [15:0] left_next;
  logic        armed_reg;
  logic        armed_next;
  logic [3:0]  grant_n_reg;
  logic [3:0]  grant_n_next;
  logic        tc_reg;
  logic        tc_next;
  logic        act_reg;
  logic        act_next;
  logic        cpu_done_reg;
  logic        cpu_done_next;
  logic        cyc_end;

  always_comb begin
    state_next   = state_reg;
    ch_next      = ch_reg;
    cyc_next     = cyc_reg;
    grant_n_next = dma_hs_pkg::GRANT_N_IDLE;
    tc_next      = 1'b0;
    act_next     = 1'b0;
    cyc_end      = 1'b0;
    case (state_reg)
      dma_hs_pkg::ST_IDLE: begin
        if (armed_reg && (req_s2_reg != 4'h0)) begin
          ch_next    = pick_channel(req_s2_reg);
          cyc_next   = dma_hs_pkg::CYCLE_CNT_V;
          state_next = dma_hs_pkg::ST_GRANT;
        end
      end
      dma_hs_pkg::ST_GRANT: begin
        grant_n_next[ch_reg] = 1'b0;
        act_next             = 1'b1;
        if (cyc_reg > 4'h1) begin
          cyc_next = cyc_reg - 4'h1;
        end else begin
          state_next = dma_hs_pkg::ST_WAIT;
        end
      end
      dma_hs_pkg::ST_WAIT: begin
        grant_n_next[ch_reg] = 1'b0;
        act_next             = 1'b1;
        if (rdy_s2_reg) begin
          grant_n_next = dma_hs_pkg::GRANT_N_IDLE;
          act_next     = 1'b0;
          cyc_end      = 1'b1;
          state_next   = dma_hs_pkg::ST_DONE;
          tc_next      = is_last(left_reg);
        end
      end
      dma_hs_pkg::ST_DONE: begin
        state_next = dma_hs_pkg::ST_IDLE;
      end
      default: begin
        state_next = dma_hs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      state_reg   <= dma_hs_pkg::ST_IDLE;
      ch_reg      <= 2'h0;
      cyc_reg     <= 4'h0;
      grant_n_reg <= dma_hs_pkg::GRANT_N_IDLE;
      tc_reg      <= 1'b0;
      act_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ch_reg      <= ch_next;
      cyc_reg     <= cyc_next;
      grant_n_reg <= grant_n_next;
      tc_reg      <= tc_next;
      act_reg     <= act_next;
    end
  end

  // ---------------------------------------------------------------
  // Transfer length and arming
  // ---------------------------------------------------------------
  always_comb begin
    left_next  = left_reg;
    armed_next = armed_reg;
    // Count down to the last cycle
    if (cyc_end) begin
      if (is_last(left_reg)) begin
        armed_next = 1'b0;
        left_next  = dma_hs_pkg::XFER_LEN_RST;
      end else begin
        left_next  = left_reg - 16'h0001;
      end
    end
    // A start in the closing cycle wins over the disarm
    if (xfer_start) begin
      armed_next = 1'b1;
      left_next  = xfer_len;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      left_reg  <= dma_hs_pkg::XFER_LEN_RST;
      armed_reg <= 1'b0;
    end else begin
      left_reg  <= left_next;
      armed_reg <= armed_next;
    end
  end

  // ---------------------------------------------------------------
  // Processor cycle pass-through
  // ---------------------------------------------------------------
  always_comb begin
    cpu_done_next = cpu_cycle;
  end

  always_ff @(posedge clk_sys or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      cpu_done_reg <= 1'b0;
    end else begin
      cpu_done_reg <= cpu_done_next;
    end
  end

  assign dma_grant_n_lines   = grant_n_reg;
  assign transfer_count_done = tc_reg;
  assign dma_cycle_active    = act_reg;
  assign cpu_cycle_done      = cpu_done_reg;

endmodule

//--- rtl/dma_hs_pkg.sv
/*
  Constants for the DMA handshake and ready block.
  Assumes one 10 MHz clock and no software-reachable registers.
*/
package dma_hs_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          CHANNELS        = 4;
  localparam int          CH_W            = 2;
  // Default bus cycle length in ns and in clock cycles
  localparam int          CYCLE_NS        = 300;
  localparam int          CYCLE_CNT       = (CYCLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0]  CYCLE_CNT_V     = 4'(CYCLE_CNT);
  localparam logic [3:0]  GRANT_N_IDLE    = 4'hf;
  localparam logic [15:0] XFER_LEN_RST    = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_GRANT = 2'b01,
    ST_WAIT  = 2'b10,
    ST_DONE  = 2'b11
  } dma_state_t;
endpackage

//--- dv/dma_periph_model.sv
/* Peripheral and ready-slave model for the DMA handshake block.
   Assumes the bench gives the wanted requests and the stretch length. */
`timescale 1ns/1ps
module dma_periph_model (
  // Bus side
  input  wire logic       clk_sys,
  input  wire logic [3:0] dma_grant_n_lines,
  output logic      [3:0] dma_request_lines,
  output logic            ready,
  // Bench control
  input  wire logic [3:0] want,
  input  wire logic [3:0] hold_cycles
);
  logic [3:0] cnt_reg;
  logic       seen_reg;
  // Acts just after each rising edge, on the grant the block has just launched
  initial begin
    dma_request_lines = 4'h0;
    ready             = 1'b1;
    cnt_reg           = 4'h0;
    seen_reg          = 1'b0;
    forever begin
      @(posedge clk_sys);
      #1;
      dma_request_lines = want & dma_grant_n_lines;
      // low once granted, released when done
      if (!(&dma_grant_n_lines) && !seen_reg) begin
        cnt_reg = hold_cycles;
        ready   = (hold_cycles == 4'h0);
      end else if (cnt_reg > 4'h1) begin
        cnt_reg = cnt_reg - 4'h1;
      end else begin
        cnt_reg = 4'h0;
        ready   = 1'b1;
      end
      seen_reg = !(&dma_grant_n_lines);
    end
  end
endmodule

//--- dv/dma_handshake_properties.sv
/* Port checker for the DMA handshake block.
   Assumes one clock and the pin reset. */
`timescale 1ns/1ps
module dma_handshake_properties (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Inputs watched
  input wire logic       cpu_cycle,
  input wire logic       ready,
  // Outputs watched
  input wire logic       transfer_count_done,
  input wire logic       dma_cycle_active,
  input wire logic       cpu_cycle_done,
  input wire logic [3:0] dma_grant_n_lines
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_one; $onehot0(~dma_grant_n_lines) && (dma_cycle_active == !(&dma_grant_n_lines)); endproperty
  a_one: assert property (p_one) else $error("grant not single");
  property p_min; $rose(dma_cycle_active) |-> dma_cycle_active[*3]; endproperty
  a_min: assert property (p_min) else $error("cycle too short");
  property p_hold; (dma_cycle_active && !ready && !cpu_cycle)[*3] |=> dma_cycle_active; endproperty
  a_hold: assert property (p_hold) else $error("no stretch");
  property p_end; $rose(dma_cycle_active) ##0 ready[*5] |-> !dma_cycle_active; endproperty
  a_end: assert property (p_end) else $error("cycle too long");
  property p_tc; transfer_count_done |-> $rose(&dma_grant_n_lines) ##1 !transfer_count_done; endproperty
  a_tc: assert property (p_tc) else $error("bad count pulse");
  property p_cpu; cpu_cycle_done == $past(cpu_cycle); endproperty
  a_cpu: assert property (p_cpu) else $error("cpu cycle altered");
  c_tc: cover property (transfer_count_done);
  c_str: cover property ((dma_cycle_active && !ready)[*3]);
  c_cpu: cover property (cpu_cycle && !ready);
endmodule
bind dma_handshake dma_handshake_properties chk (.clk_sys(clk_sys), .nrst(nrst), .cpu_cycle(cpu_cycle),
  .ready(ready), .transfer_count_done(transfer_count_done), .dma_cycle_active(dma_cycle_active),
  .cpu_cycle_done(cpu_cycle_done), .dma_grant_n_lines(dma_grant_n_lines));

//--- dv/dma_handshake_tb.sv
/* Bench for the DMA handshake block.
   Assumes the peripheral model on the pin side. */
`timescale 1ns/1ps
module dma_handshake_tb;
  logic        clk_sys = 0, nrst = 0, xfer_start = 0, cpu_cycle = 0, ready, tc, act, cdone;
  logic [15:0] xfer_len = 16'h0001;
  logic [3:0]  want = 4'h0, hold = 4'h0, req, gnt, g;
  int          errors = 0, total_checks = 0, n, tcs;
  always #50 clk_sys = ~clk_sys;
  dma_handshake dut (.clk_sys(clk_sys), .nrst(nrst), .xfer_start(xfer_start), .xfer_len(xfer_len),
    .cpu_cycle(cpu_cycle), .dma_request_lines(req), .ready(ready), .dma_grant_n_lines(gnt),
    .transfer_count_done(tc), .dma_cycle_active(act), .cpu_cycle_done(cdone));
  dma_periph_model peer (.clk_sys(clk_sys), .dma_grant_n_lines(gnt), .dma_request_lines(req),
    .ready(ready), .want(want), .hold_cycles(hold));
  task check(string what, logic [3:0] seen, logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  // Runs one transfer; counts active cycles and count pulses
  task run(logic [3:0] w, logic [3:0] h, logic [15:0] len);
    xfer_len = len;
    hold = h;
    want = w;
    // Let stale requests drain through the synchroniser before arming
    repeat (4) tick;
    xfer_start = 1;
    tick;
    xfer_start = 0;
    n = 0;
    tcs = 0;
    g = 4'h0;
    for (int i = 0; i < 300 && tcs == 0; i++) begin
      tick;
      n += act;
      tcs += tc;
      if (act === 1'b1) g = gnt;
    end
    want = 4'h0;
    tick;
    tcs += tc;
  endtask
  task t_prio;
    run(4'h6, 4'h0, 16'h0001);
    check("grant", g, 4'hd);
    check("active", n[3:0], 4'(dma_hs_pkg::CYCLE_CNT));
    check("tc", tcs[3:0], 4'h1);
    $display("prio done");
  endtask
  task t_stretch;
    run(4'h8, 4'h6, 16'h0002);
    check("grant", g, 4'h7);
    check("stretch", 4'(n == 2 * (dma_hs_pkg::CYCLE_CNT + 6)), 4'h1);
    check("tc", tcs[3:0], 4'h1);
    $display("stretch done");
  endtask
  // Ends a processor cycle while the slave holds ready low in a DMA cycle
  task t_cpu;
    cpu_cycle = 1;
    xfer_len = 16'h0001;
    hold = 4'h8;
    want = 4'h1;
    repeat (4) tick;
    xfer_start = 1;
    tick;
    xfer_start = 0;
    for (int i = 0; i < 300 && ready !== 1'b0; i++) tick;
    check("cpu", 4'(cdone), 4'h1);
    cpu_cycle = 0;
    tick;
    check("cpu", 4'(cdone), 4'h0);
    check("ready", 4'(ready), 4'h0);
    check("busy", 4'(act), 4'h1);
    for (int i = 0; i < 300 && tc !== 1'b1; i++) tick;
    check("tc", 4'(tc), 4'h1);
    want = 4'h0;
    tick;
    $display("cpu done");
  endtask
  // Tests take under two hundred cycles; give up after 5000
  initial begin
    #500000;
    errors++;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 nrst = 1;
    repeat (3) tick;
    t_prio;
    t_stretch;
    t_cpu;
    conclude;
  end
endmodule
